// ### verilog/pmt_mii_timing.sv
// MII-side clocking, latency and reset sequencing of a 10/100 PHY.
// Assumes the MAC drives transmit signals off mii_tx_clk, and that the
// recovered line receive clock delivers at most one nibble per edge.
// What this block does
// - Receive clock 40 ns or 400 ns period.
// - Transmit clock 40 ns or 400 ns period.
// - Capture transmit signals on transmit clock rise.
// - Receive outputs stable around receive clock rise.
// - 10M receive latency at most 7 bits.
// - 10M transmit latency at most 2 bits.
// - 100M start symbol out within 3 bits.
// - 100M transmit latency never above 18 bits.
// - 100M receive latency at most 17 bits.
// - 10M half-duplex carrier on within 2 bits of enable.
// - 10M half-duplex carrier off 0 to 4 bits after enable.
// - Power-on initialization 40 to 500 ms.
// - Reset isolates outputs within 60 ns.
// - Valid transmit clock 35 to 500 ms after release.
`timescale 1ns/1ps
module pmt_mii_timing
    import pmt_pkg::*;
#(
    parameter int INIT_CYCLES = pmt_pkg::INIT_CYCLES_DEF,
    parameter int DIV         = pmt_pkg::DIV_10
)
(
    // Clocks and resets
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  hardware_reset_low,
    input  wire logic                  line_rx_clk,
    // Mode pins
    input  wire logic                  speed_100_pin,
    input  wire logic                  full_duplex_pin,
    // MII transmit
    input  wire logic [NIBBLE_W-1:0]   mii_txd,
    input  wire logic                  mii_tx_en,
    input  wire logic                  mii_tx_er,
    output logic                       mii_tx_clk,
    // MII receive
    output logic                       mii_rx_clk,
    output logic [NIBBLE_W-1:0]        mii_rxd,
    output logic                       mii_rx_dv,
    output logic                       mii_rx_er,
    output logic                       mii_crs,
    output logic                       mii_oe,
    // Line receive, line_rx_clk domain
    input  wire logic [NIBBLE_W-1:0]   line_receive_pair_nibble,
    input  wire logic                  line_receive_pair_valid,
    input  wire logic                  line_receive_pair_error,
    input  wire logic                  line_receive_pair_active,
    // Line transmit
    output logic [NIBBLE_W-1:0]        line_transmit_pair_nibble,
    output logic                       line_transmit_pair_en,
    output logic                       line_transmit_pair_er,
    // Status
    output logic                       init_done
);
    import pmt_pkg::*;

    localparam int ICW = $clog2(INIT_CYCLES + 1);

    generate
        if (INIT_CYCLES < 1)
        begin : g_chk_init
            $error("INIT_CYCLES must be at least 1");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Reset: asynchronous assert from either source, synchronous release
    // ------------------------------------------------------------------
    logic       hw_rst_async;
    logic [1:0] rst_sync_q;
    logic       core_rst;
    logic [1:0] lrst_sync_q;
    logic       line_rst;

    // Pin low or power-on reset forces isolation at once, no clock needed
    assign hw_rst_async = rst | ~hardware_reset_low;

    always_ff @(posedge ref_clk or posedge hw_rst_async)
    begin
        if (hw_rst_async)
        begin
            rst_sync_q <= RST_SYNC_SET;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b0};
        end
    end

    assign core_rst = rst_sync_q[1];

    always_ff @(posedge line_rx_clk or posedge hw_rst_async)
    begin
        if (hw_rst_async)
        begin
            lrst_sync_q <= RST_SYNC_SET;
        end
        else
        begin
            lrst_sync_q <= {lrst_sync_q[0], 1'b0};
        end
    end

    assign line_rst = lrst_sync_q[1];

    // ------------------------------------------------------------------
    // Mode pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] spd_sync_q;
    logic [1:0] fdx_sync_q;

    always_ff @(posedge ref_clk or posedge core_rst)
    begin
        if (core_rst)
        begin
            spd_sync_q <= 2'h0;
            fdx_sync_q <= 2'h0;
        end
        else
        begin
            spd_sync_q <= {spd_sync_q[0], speed_100_pin};
            fdx_sync_q <= {fdx_sync_q[0], full_duplex_pin};
        end
    end

    // ------------------------------------------------------------------
    // Initialization sequencer
    // ------------------------------------------------------------------
    pmt_state_e     state_q;
    pmt_state_e     state_d;
    logic [ICW-1:0] init_cnt_q;
    logic [ICW-1:0] init_cnt_d;
    logic           init_end;
    logic           run;
    logic           speed_q;
    logic           speed_d;
    logic           duplex_q;
    logic           duplex_d;

    // One wait serves both the power-on and the pin reset windows
    assign init_end = (state_q == PMT_ST_INIT) && (init_cnt_q == ICW'(INIT_CYCLES - 1));

    always_comb
    begin
        state_d    = state_q;
        init_cnt_d = init_cnt_q;
        unique case (state_q)
            PMT_ST_INIT:
            begin
                init_cnt_d = init_cnt_q + ICW'(1);
                if (init_end)
                begin
                    state_d    = PMT_ST_RUN;
                    init_cnt_d = '0;
                end
            end
            PMT_ST_RUN:
            begin
                init_cnt_d = '0;
            end
        endcase
    end

    // Mode is taken while the clocks are stopped, so the clock mux never glitches
    assign speed_d  = (state_q == PMT_ST_INIT) ? spd_sync_q[1] : speed_q;
    assign duplex_d = (state_q == PMT_ST_INIT) ? fdx_sync_q[1] : duplex_q;

    always_ff @(posedge ref_clk or posedge core_rst)
    begin
        if (core_rst)
        begin
            state_q    <= PMT_ST_INIT;
            init_cnt_q <= '0;
            speed_q    <= 1'b0;
            duplex_q   <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            init_cnt_q <= init_cnt_d;
            speed_q    <= speed_d;
            duplex_q   <= duplex_d;
        end
    end

    assign run       = (state_q == PMT_ST_RUN);
    assign init_done = run;
    assign mii_oe    = run;

    // ------------------------------------------------------------------
    // MII clocks
    // ------------------------------------------------------------------
    logic sample_stb;
    logic launch_stb;

    pmt_clk_gen #(
        .DIV        (DIV)
    ) u_clk_gen (
        .ref_clk    (ref_clk),
        .rst        (core_rst),
        .run        (run),
        .speed_100  (speed_q),
        .tx_clk     (mii_tx_clk),
        .rx_clk     (mii_rx_clk),
        .sample_stb (sample_stb),
        .launch_stb (launch_stb)
    );

    // ------------------------------------------------------------------
    // Transmit capture; the capture flops drive the line directly
    // ------------------------------------------------------------------
    logic [NIBBLE_W-1:0] txd_q;
    logic                tx_en_q;
    logic                tx_er_q;

    always_ff @(posedge ref_clk or posedge core_rst)
    begin
        if (core_rst)
        begin
            txd_q   <= '0;
            tx_en_q <= 1'b0;
            tx_er_q <= 1'b0;
        end
        else if (!run)
        begin
            txd_q   <= '0;
            tx_en_q <= 1'b0;
            tx_er_q <= 1'b0;
        end
        else if (sample_stb)
        begin
            txd_q   <= mii_txd;
            tx_en_q <= mii_tx_en;
            tx_er_q <= mii_tx_er;
        end
    end

    // No extra stage: line sees the nibble one clock-to-q after sampling
    assign line_transmit_pair_nibble = txd_q;
    assign line_transmit_pair_en     = tx_en_q;
    assign line_transmit_pair_er     = tx_er_q;

    // ------------------------------------------------------------------
    // Line receive domain: hold word and toggle per nibble
    // ------------------------------------------------------------------
    logic [RX_WORD_W-1:0] lhold_q;
    logic                 ltog_q;

    always_ff @(posedge line_rx_clk or posedge line_rst)
    begin
        if (line_rst)
        begin
            lhold_q <= '0;
            ltog_q  <= 1'b0;
        end
        else if (line_receive_pair_valid)
        begin
            lhold_q <= {line_receive_pair_error, line_receive_pair_nibble};
            ltog_q  <= ~ltog_q;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into ref_clk: toggle event and activity level
    // ------------------------------------------------------------------
    logic [2:0]           tog_sync_q;
    logic [1:0]           act_sync_q;
    logic                 rx_new;
    logic [RX_WORD_W-1:0] rx_word_q;
    logic                 fresh_q;
    logic                 fresh_d;

    always_ff @(posedge ref_clk or posedge core_rst)
    begin
        if (core_rst)
        begin
            tog_sync_q <= 3'h0;
            act_sync_q <= 2'h0;
        end
        else
        begin
            tog_sync_q <= {tog_sync_q[1:0], ltog_q};
            act_sync_q <= {act_sync_q[0], line_receive_pair_active};
        end
    end

    // Hold word settled two ref edges before the toggle is seen here
    assign rx_new  = tog_sync_q[2] ^ tog_sync_q[1];
    assign fresh_d = rx_new | (fresh_q & ~launch_stb);

    always_ff @(posedge ref_clk or posedge core_rst)
    begin
        if (core_rst)
        begin
            rx_word_q <= '0;
            fresh_q   <= 1'b0;
        end
        else
        begin
            fresh_q <= fresh_d;
            if (rx_new)
            begin
                rx_word_q <= lhold_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Receive outputs, launched away from the rx_clk rise
    // ------------------------------------------------------------------
    logic [NIBBLE_W-1:0] rxd_q;
    logic                rx_dv_q;
    logic                rx_er_q;

    always_ff @(posedge ref_clk or posedge core_rst)
    begin
        if (core_rst)
        begin
            rxd_q   <= '0;
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
        end
        else if (!run)
        begin
            rxd_q   <= '0;
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
        end
        else if (launch_stb)
        begin
            // Next nibble period carries the newest word
            rxd_q   <= fresh_q ? rx_word_q[NIBBLE_W-1:0] : '0;
            rx_dv_q <= fresh_q;
            rx_er_q <= fresh_q & rx_word_q[RX_WORD_ERR_BIT];
        end
    end

    assign mii_rxd   = rxd_q;
    assign mii_rx_dv = rx_dv_q;
    assign mii_rx_er = rx_er_q;

    // ------------------------------------------------------------------
    // Carrier sense
    // ------------------------------------------------------------------
    logic [CRS_CNT_W-1:0] crs_hold_q;
    logic [CRS_CNT_W-1:0] crs_hold_d;
    logic                 tx_en_fall;
    logic                 half_10;
    logic                 crs_tx;
    logic                 crs_q;
    logic                 crs_d;
    logic                 tx_en_prev_q;

    assign half_10    = ~speed_q & ~duplex_q;
    assign tx_en_fall = tx_en_prev_q & ~tx_en_q;

    // In 10M half duplex, stretch carrier by two bit times after transmit enable drops
    assign crs_hold_d = (tx_en_fall && half_10) ? CRS_CNT_W'(CRS_HOLD_CYCLES)
                      : (crs_hold_q != '0) ? crs_hold_q - CRS_CNT_W'(1)
                      : '0;

    // Fall cycle bridges the gap before the hold count loads
    assign crs_tx = ~duplex_q & (tx_en_q | tx_en_fall | (crs_hold_q != '0));
    assign crs_d  = run & (crs_tx | act_sync_q[1]);

    always_ff @(posedge ref_clk or posedge core_rst)
    begin
        if (core_rst)
        begin
            crs_hold_q   <= '0;
            tx_en_prev_q <= 1'b0;
            crs_q        <= 1'b0;
        end
        else
        begin
            crs_hold_q   <= crs_hold_d;
            tx_en_prev_q <= tx_en_q;
            crs_q        <= crs_d;
        end
    end

    assign mii_crs = crs_q;

endmodule

// ### verilog/pmt_pkg.sv
// Shared constants for the MII timing, latency and reset block.
// Assumes a 25 MHz reference clock feeding all MII-side logic.
package pmt_pkg;

    // Reference clock
    localparam int REF_PERIOD_NS      = 40;

    // MII clock periods at both speeds
    localparam int MII_PERIOD_100_NS  = 40;
    localparam int MII_PERIOD_10_NS   = 400;
    localparam int DIV_10             = MII_PERIOD_10_NS / REF_PERIOD_NS;
    localparam int DIV_100            = MII_PERIOD_100_NS / REF_PERIOD_NS;

    // Bit times
    localparam int BIT_10_NS          = 100;
    localparam int BIT_100_NS         = 10;

    // Latency bounds in bit times, tenths where typical has a fraction
    localparam int RX_LAT_10_MAX_BITS  = 7;
    localparam int TX_LAT_10_MAX_BITS  = 2;
    localparam int TX_LAT_100_MAX_BITS = 3;
    localparam int TX_LAT_100_STD_BITS = 18;
    localparam int RX_LAT_100_MAX_BITS = 17;

    // Carrier sense during 10 Mb/s half-duplex transmit
    localparam int CRS_ON_MAX_BITS    = 2;
    localparam int CRS_OFF_TYP_BITS   = 2;
    localparam int CRS_OFF_MAX_BITS   = 4;
    localparam int CRS_HOLD_CYCLES    = (CRS_OFF_TYP_BITS * BIT_10_NS) / REF_PERIOD_NS;
    localparam int CRS_CNT_W          = 3;

    // Management clock limits kept by the station
    localparam int MDC_HIGH_MIN_NS    = 160;
    localparam int MDC_LOW_MIN_NS     = 160;
    localparam int MDC_PERIOD_MIN_NS  = 400;

    // Reset timing
    localparam int RST_PULSE_MIN_NS   = 200;
    localparam int ISOLATE_MAX_NS     = 60;
    localparam int INIT_MIN_MS        = 40;
    localparam int INIT_MAX_MS        = 500;
    localparam int INIT_TYP_MS        = 45;
    localparam int INIT_CYCLES_DEF    = (INIT_TYP_MS * 1000000) / REF_PERIOD_NS;

    // Rx word crossing: error bit above the nibble
    localparam int NIBBLE_W           = 4;
    localparam int RX_WORD_W          = NIBBLE_W + 1;
    localparam int RX_WORD_ERR_BIT    = NIBBLE_W;

    // Reset synchroniser fill value
    localparam logic [1:0] RST_SYNC_SET = 2'h3;

    typedef enum logic {PMT_ST_INIT, PMT_ST_RUN} pmt_state_e;

endpackage

// ### verilog/pmt_clk_gen.sv
// MII transmit and receive clock generator with sampling strobes.
// Assumes ref_clk is the 25 MHz reference and rst releases synchronously.
`timescale 1ns/1ps
module pmt_clk_gen
#(
    parameter int DIV = pmt_pkg::DIV_10
)
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Control
    input  wire logic run,
    input  wire logic speed_100,
    // Clocks out
    output logic      tx_clk,
    output logic      rx_clk,
    // Strobes on the ref_clk edge that matches a clock edge
    output logic      sample_stb,
    output logic      launch_stb
);
    import pmt_pkg::*;

    localparam int CW = $clog2(DIV);

    generate
        if (DIV < 2 || (DIV % 2) != 0)
        begin : g_chk
            $error("DIV must be even and at least 2");
        end
    endgenerate

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          div_q;
    logic          wrap;
    logic          div_d;

    assign wrap  = (cnt_q == CW'(DIV - 1));
    // Parked at the last count so the first run edge opens a full high phase
    assign cnt_d = !run ? CW'(DIV - 1) : wrap ? '0 : cnt_q + CW'(1);
    assign div_d = run && (cnt_d < CW'(DIV / 2));

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= CW'(DIV - 1);
            div_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            div_q <= div_d;
        end
    end

    // Fast mode passes the reference through; rx is inverted so data launched
    // on a ref rise sits mid-period at the rx_clk rise
    assign tx_clk     = run & (speed_100 ? ref_clk : div_q);
    assign rx_clk     = run & (speed_100 ? ~ref_clk : div_q);
    assign sample_stb = run & (speed_100 | wrap);
    assign launch_stb = run & (speed_100 | (cnt_q == CW'(DIV / 2 - 1)));

endmodule

// ### test/pmt_mii_timing_asserts.sv
// Port-level assertions for the MII timing, latency and reset block.
// Assumes a bind onto pmt_mii_timing with a 10 Mb/s divider of 10.
`timescale 1ns/1ps
module pmt_mii_timing_asserts
#(
    parameter int INIT_CYCLES = 20,
    parameter int DIV         = 10
)
(
    // Clock, resets, mode pins and line activity
    input wire logic                        ref_clk,
    input wire logic                        rst,
    input wire logic                        hardware_reset_low,
    input wire logic                        speed_100_pin,
    input wire logic                        full_duplex_pin,
    input wire logic                        line_receive_pair_active,
    // MII
    input wire logic [pmt_pkg::NIBBLE_W-1:0] mii_txd,
    input wire logic                        mii_tx_en,
    input wire logic                        mii_tx_er,
    input wire logic                        mii_tx_clk,
    input wire logic                        mii_rx_clk,
    input wire logic [pmt_pkg::NIBBLE_W-1:0] mii_rxd,
    input wire logic                        mii_rx_dv,
    input wire logic                        mii_rx_er,
    input wire logic                        mii_crs,
    input wire logic                        mii_oe,
    // Line transmit and status
    input wire logic [pmt_pkg::NIBBLE_W-1:0] line_transmit_pair_nibble,
    input wire logic                        line_transmit_pair_en,
    input wire logic                        line_transmit_pair_er,
    input wire logic                        init_done
);
    import pmt_pkg::*;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst || !hardware_reset_low);

    a_iso_on_reset: assert property (disable iff (1'b0) (rst || !hardware_reset_low) |->
        !mii_oe && !init_done && !mii_rx_dv && !line_transmit_pair_en) else $error("outputs live in reset");
    a_oe_follows_init: assert property (mii_oe == init_done) else $error("oe differs from init");
    a_quiet_in_init: assert property (!init_done |-> !mii_tx_clk && !mii_rx_clk && !mii_rx_dv
        && !mii_crs && !line_transmit_pair_en) else $error("activity before init done");
    a_tx_capture_edge: assert property (init_done && $past(init_done) && line_transmit_pair_en
        && $changed(line_transmit_pair_nibble) |-> line_transmit_pair_nibble == $past(mii_txd)
        && line_transmit_pair_er == $past(mii_tx_er) && $past(mii_tx_en)) else $error("tx nibble not captured");
    a_crs_on_time: assert property (init_done && !full_duplex_pin && !speed_100_pin
        && $rose(line_transmit_pair_en) |-> ##[0:5] mii_crs) else $error("carrier late");
    a_crs_off_time: assert property (init_done && !full_duplex_pin && !speed_100_pin
        && !line_receive_pair_active && $fell(line_transmit_pair_en) |-> ##[1:10] !mii_crs)
        else $error("carrier held too long");
    a_crs_full_dup: assert property ((full_duplex_pin && !line_receive_pair_active)[*8] |-> !mii_crs)
        else $error("carrier from transmit in full duplex");
    a_rx_idle_zero: assert property (!mii_rx_dv |-> mii_rxd == '0 && !mii_rx_er)
        else $error("receive data without valid");
    a_clk_10_shape: assert property (init_done && !speed_100_pin && $rose(mii_tx_clk) |->
        mii_tx_clk[*5] ##1 !mii_tx_clk[*5] ##1 mii_tx_clk) else $error("10M clock not 400 ns");
    a_clk_10_same: assert property (!speed_100_pin |-> mii_rx_clk == mii_tx_clk)
        else $error("10M receive clock differs");
    a_clk_100_run: assert property (@(negedge ref_clk) disable iff (rst || !hardware_reset_low)
        init_done && speed_100_pin |-> mii_tx_clk && !mii_rx_clk) else $error("100M clock wrong");
endmodule

bind pmt_mii_timing pmt_mii_timing_asserts #(.INIT_CYCLES(INIT_CYCLES), .DIV(DIV)) u_asserts (
    .ref_clk(ref_clk), .rst(rst), .hardware_reset_low(hardware_reset_low), .speed_100_pin(speed_100_pin),
    .full_duplex_pin(full_duplex_pin), .line_receive_pair_active(line_receive_pair_active),
    .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er), .mii_tx_clk(mii_tx_clk),
    .mii_rx_clk(mii_rx_clk), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er),
    .mii_crs(mii_crs), .mii_oe(mii_oe), .line_transmit_pair_nibble(line_transmit_pair_nibble),
    .line_transmit_pair_en(line_transmit_pair_en), .line_transmit_pair_er(line_transmit_pair_er),
    .init_done(init_done));

// ### test/pmt_mac_model.sv
// Behavioural MAC transmit side facing the MII.
// Assumes the block sources mii_tx_clk and samples on its rise.
`timescale 1ns/1ps
module pmt_mac_model
(
    // Clock from the block
    input  wire logic                        mii_tx_clk,
    // Transmit signals
    output logic [pmt_pkg::NIBBLE_W-1:0]     mii_txd,
    output logic                             mii_tx_en,
    output logic                             mii_tx_er
);
    import pmt_pkg::*;

    initial
    begin
        mii_txd   = 4'h0;
        mii_tx_en = 1'b0;
        mii_tx_er = 1'b0;
    end

    // Launch just after the rise, hold for the whole period
    task automatic send(input logic [4:0] v);
        @(posedge mii_tx_clk);
        mii_txd   <= v[3:0];
        mii_tx_en <= 1'b1;
        mii_tx_er <= v[4];
    endtask

    // Released data is inverted so stale values never look valid
    task automatic stop();
        @(posedge mii_tx_clk);
        mii_tx_en <= 1'b0;
        mii_tx_er <= 1'b0;
        mii_txd   <= ~mii_txd;
    endtask
endmodule

// ### test/pmt_mii_timing_tb.sv
// Self-checking bench for the MII timing, latency and reset block.
// Assumes a 25 MHz reference and a 160 ns recovered line clock.
`timescale 1ns/1ps
module pmt_mii_timing_tb;
    import pmt_pkg::*;
    localparam int INIT = 20;
    localparam int CEIL = 3000;

    logic       ref_clk;
    logic       line_rx_clk;
    logic       rst;
    logic       hardware_reset_low;
    logic       speed_100_pin;
    logic       full_duplex_pin;
    logic [3:0] mii_txd;
    logic       mii_tx_en;
    logic       mii_tx_er;
    logic       mii_tx_clk;
    logic       mii_rx_clk;
    logic [3:0] mii_rxd;
    logic       mii_rx_dv;
    logic       mii_rx_er;
    logic       mii_crs;
    logic       mii_oe;
    logic [3:0] line_receive_pair_nibble;
    logic       line_receive_pair_valid;
    logic       line_receive_pair_error;
    logic       line_receive_pair_active;
    logic [3:0] line_transmit_pair_nibble;
    logic       line_transmit_pair_en;
    logic       line_transmit_pair_er;
    logic       init_done;
    logic [4:0] tx_q[$];
    logic [4:0] rx_q[$];
    logic [4:0] tx_exp;
    logic [4:0] rx_exp;
    int         fail_count = 0;
    int         compares = 0;
    int         cycles = 0;

    pmt_mii_timing #(.INIT_CYCLES(INIT), .DIV(10)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .hardware_reset_low(hardware_reset_low), .line_rx_clk(line_rx_clk),
        .speed_100_pin(speed_100_pin), .full_duplex_pin(full_duplex_pin), .mii_txd(mii_txd),
        .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er), .mii_tx_clk(mii_tx_clk), .mii_rx_clk(mii_rx_clk),
        .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mii_crs(mii_crs), .mii_oe(mii_oe),
        .line_receive_pair_nibble(line_receive_pair_nibble), .line_receive_pair_valid(line_receive_pair_valid),
        .line_receive_pair_error(line_receive_pair_error), .line_receive_pair_active(line_receive_pair_active),
        .line_transmit_pair_nibble(line_transmit_pair_nibble), .line_transmit_pair_en(line_transmit_pair_en),
        .line_transmit_pair_er(line_transmit_pair_er), .init_done(init_done));

    pmt_mac_model u_mac (.mii_tx_clk(mii_tx_clk), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial
    begin
        line_rx_clk = 1'b0;
        #7;
        forever #80 line_rx_clk = ~line_rx_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wait_init();
        int n;
        n = 0;
        while (mii_oe !== 1'b1 && n < 200)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(n >= INIT && n <= INIT + 4, 1);
    endtask

    task automatic tx_frame(input int n, input logic crs_exp);
        logic [4:0] v;
        for (int i = 0; i < n; i++)
        begin
            v = {5'($urandom % 4 == 0) << 4} | 5'($urandom % 16);
            tx_q.push_back(v);
            u_mac.send(v);
            if (i == 3)
            begin
                #5;
                check(mii_crs, crs_exp);
            end
        end
        u_mac.stop();
    endtask

    // Line side: one nibble per valid edge, gap edges between
    task automatic rx_frame(input int n, input int gap);
        logic [4:0] v;
        @(posedge line_rx_clk);
        line_receive_pair_active <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            v = {5'($urandom % 4 == 0) << 4} | 5'($urandom % 16);
            rx_q.push_back(v);
            @(posedge line_rx_clk);
            line_receive_pair_nibble <= v[3:0];
            line_receive_pair_error  <= v[4];
            line_receive_pair_valid  <= 1'b1;
            repeat (gap)
            begin
                @(posedge line_rx_clk);
                line_receive_pair_valid  <= 1'b0;
                line_receive_pair_nibble <= ~v[3:0];
            end
        end
        @(posedge line_rx_clk);
        line_receive_pair_valid  <= 1'b0;
        line_receive_pair_active <= 1'b0;
        repeat (40) @(posedge ref_clk);
        check(rx_q.size(), 0);
    endtask

    always @(negedge mii_tx_clk)
    begin
        if (line_transmit_pair_en === 1'b1)
        begin
            tx_exp = (tx_q.size() > 0) ? tx_q.pop_front() : 'x;
            check({line_transmit_pair_er, line_transmit_pair_nibble}, tx_exp);
        end
    end

    always @(posedge mii_rx_clk)
    begin
        if (mii_rx_dv === 1'b1)
        begin
            rx_exp = (rx_q.size() > 0) ? rx_q.pop_front() : 'x;
            check({mii_rx_er, mii_rxd}, rx_exp);
        end
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == CEIL)
        begin
            fail_count++;
            final_report();
        end
    end

    initial
    begin
        void'($urandom(32'h1A65));
        rst                      = 1'b1;
        hardware_reset_low       = 1'b1;
        speed_100_pin            = 1'b0;
        full_duplex_pin          = 1'b0;
        line_receive_pair_nibble = 4'h0;
        line_receive_pair_valid  = 1'b0;
        line_receive_pair_error  = 1'b0;
        line_receive_pair_active = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        wait_init();
        // 10 Mb/s half duplex
        tx_frame(8, 1'b1);
        repeat (21) @(posedge ref_clk);
        #1;
        check(mii_crs, 1'b0);
        check(tx_q.size(), 0);
        rx_frame(6, 2);
        // Pin reset of 200 ns, then 100 Mb/s full duplex
        @(posedge ref_clk);
        hardware_reset_low <= 1'b0;
        speed_100_pin      <= 1'b1;
        full_duplex_pin    <= 1'b1;
        #2;
        check(mii_oe, 1'b0);
        check(mii_tx_clk, 1'b0);
        repeat (5) @(posedge ref_clk);
        hardware_reset_low <= 1'b1;
        wait_init();
        tx_frame(8, 1'b0);
        repeat (4) @(posedge ref_clk);
        check(tx_q.size(), 0);
        rx_frame(8, 0);
        final_report();
    end
endmodule
